// File: bench/ic_core_asserts.sv
// Port checks for the interrupt controller
`timescale 1ns/1ns
module ic_core_asserts import ic_pkg::*; #(
    parameter int PC_W = 13
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic instr_boundary_i,
    input wire logic [PC_W-1:0] next_pc_i,
    input wire logic return_from_irq_instr_i,
    input wire logic [PC_W-1:0] stack_top_i,
    input wire logic stack_full_i,
    input wire logic stack_push_o,
    input wire logic [PC_W-1:0] stack_push_data_o,
    input wire logic stack_pop_o,
    input wire logic pc_load_o,
    input wire logic [PC_W-1:0] pc_load_addr_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    chk_push_with_load: assert property (stack_push_o |-> pc_load_o && !stack_pop_o)
        else $error("push without vector load");
    chk_push_next_pc: assert property (stack_push_o |-> stack_push_data_o == $past(next_pc_i))
        else $error("pushed address is not the next address");
    chk_take_boundary: assert property (stack_push_o |-> $past(instr_boundary_i) && !$past(return_from_irq_instr_i))
        else $error("take away from a boundary");
    chk_return_pop: assert property (return_from_irq_instr_i |=> stack_pop_o && pc_load_o && pc_load_addr_o == $past(stack_top_i))
        else $error("return did not pop and resume");
    chk_full_holds: assert property (stack_full_i |=> !stack_push_o)
        else $error("take while stack full");
    chk_no_nesting: assert property (stack_push_o && !(reg_wr_i && reg_addr_i == ADDR_CTRL0) |=> !stack_push_o [*2])
        else $error("second take without enable rewrite");
    chk_vector_range: assert property (stack_push_o |-> pc_load_addr_o <= 'h24 && pc_load_addr_o >= 'h4 && pc_load_addr_o[1:0] == 2'h0)
        else $error("vector outside table");
    chk_unmapped_zero: assert property (reg_addr_i > ADDR_CMP_CTRL |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    cover property (stack_push_o);
    cover property (stack_pop_o);
    cover property (stack_full_i && instr_boundary_i);
endmodule
bind ic_core ic_core_asserts #(.PC_W(PC_W)) i_ic_core_asserts (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rdata_o(reg_rdata_o), .instr_boundary_i(instr_boundary_i), .next_pc_i(next_pc_i),
    .return_from_irq_instr_i(return_from_irq_instr_i), .stack_top_i(stack_top_i),
    .stack_full_i(stack_full_i), .stack_push_o(stack_push_o), .stack_push_data_o(stack_push_data_o),
    .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_load_addr_o(pc_load_addr_o)
);

// File: bench/ic_core_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module ic_core_tb import ic_pkg::*;;
    localparam logic [7:0] CMP_V = 8'h08;
    logic clk, rst_n, wr, p0, p1, cmp, ret_req, bnd, ret, full, push, pop, load, wake;
    logic [3:0] addr;
    logic [7:0] wd, rd;
    logic [10:0] ev;
    logic [12:0] npc, top, pdata, laddr;
    int err_count = 0;
    int cmp_count = 0;
    int loads = 0;
    int cycles = 0;
    ic_core #(.PC_W(13), .CMP_VEC(CMP_V)) i_ic_core (
        .core_clk_i(clk), .arst_n_i(rst_n), .ce_i(1'b1), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wd), .reg_rdata_o(rd), .pin0_i(p0), .pin1_i(p1), .cmp_out_i(cmp),
        .tmr0_period_evt_i(ev[0]), .tmr0_cmpa_evt_i(ev[1]), .tmr1_period_evt_i(ev[2]),
        .tmr1_cmpa_evt_i(ev[3]), .tmr2_period_evt_i(ev[4]), .tmr2_cmpa_evt_i(ev[5]),
        .low_volt_evt_i(ev[6]), .nv_write_done_evt_i(ev[7]), .conv_done_evt_i(ev[8]),
        .tb0_evt_i(ev[9]), .tb1_evt_i(ev[10]), .instr_boundary_i(bnd), .next_pc_i(npc),
        .return_from_irq_instr_i(ret), .stack_top_i(top), .stack_full_i(full), .stack_push_o(push),
        .stack_push_data_o(pdata), .stack_pop_o(pop), .pc_load_o(load), .pc_load_addr_o(laddr), .wake_o(wake)
    );
    ic_cpu_model #(.PC_W(13), .DEPTH(1)) i_ic_cpu_model (
        .core_clk_i(clk), .arst_n_i(rst_n), .ret_req_i(ret_req), .push_i(push), .push_data_i(pdata),
        .pop_i(pop), .bnd_o(bnd), .pc_o(npc), .ret_o(ret), .top_o(top), .full_o(full)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Sampled off the edge that launches the load pulse, so no race with the design
    always @(negedge clk) begin
        loads += (load === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        // Idle edge keeps back-to-back writes from re-raising the strobe at once
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        addr = a;
        @(negedge clk);
        `CHECK(rd, e)
    endtask
    task automatic gie_on();
        addr = ADDR_CTRL0;
        @(negedge clk);
        wr_reg(ADDR_CTRL0, rd | 8'h01);
    endtask
    task automatic pulse(input logic [10:0] m);
        ev = m;
        @(negedge clk);
        ev = 11'h000;
    endtask
    // Bounded waits: a missing answer shows as a mismatch, not a hang
    task automatic wait_take(input logic [7:0] v);
        for (int n = 0; n < 40 && push !== 1'b1; n++) @(negedge clk);
        `CHECK({load, laddr}, {1'b1, 5'h00, v})
        @(negedge clk);
    endtask
    task automatic ret_do();
        ret_req = 1'b1;
        @(negedge clk);
        ret_req = 1'b0;
        for (int n = 0; n < 40 && pop !== 1'b1; n++) @(negedge clk);
        `CHECK({pop, load}, 2'h3)
        @(negedge clk);
    endtask
    task automatic t_regs();
        wr_reg(4'h9, 8'hFF);
        for (int a = 0; a < 10; a++) rd_chk(a[3:0], 8'h00);
        wr_reg(ADDR_TIMER_GROUP, 8'hFF);
        rd_chk(ADDR_TIMER_GROUP, 8'hFF);
        wr_reg(ADDR_MISC_GROUP, 8'hFF);
        rd_chk(ADDR_MISC_GROUP, 8'h33);
        wr_reg(ADDR_TIMER_GROUP, 8'h00);
        wr_reg(ADDR_MISC_GROUP, 8'h00);
    endtask
    task automatic t_gate();
        int l;
        wr_reg(ADDR_CTRL0, 8'h01);
        pulse(11'h100);
        `CHECK(wake, 1'b1)
        rd_chk(ADDR_CTRL1, 8'h40);
        pulse(11'h100);
        `CHECK(wake, 1'b0)
        l = loads;
        repeat (12) @(negedge clk);
        `CHECK(loads, l)
        wr_reg(ADDR_CTRL0, 8'h00);
        wr_reg(ADDR_CTRL1, 8'h44);
        repeat (12) @(negedge clk);
        `CHECK(loads, l)
        wr_reg(ADDR_CTRL0, 8'h01);
        wait_take(VEC_CONV);
        rd_chk(ADDR_CTRL0, 8'h00);
        pulse(11'h100);
        rd_chk(ADDR_CTRL1, 8'h44);
        ret_do();
        wr_reg(ADDR_CTRL1, 8'h00);
    endtask
    task automatic t_edges();
        logic en;
        for (int c = 0; c < 5; c++) begin
            en = (c != 4);
            wr_reg(ADDR_CTRL0, {6'h00, en, 1'b0});
            wr_reg(ADDR_EDGE_SEL, {6'h00, (c == 4) ? 2'h3 : c[1:0]});
            p0 = 1'b1;
            repeat (2) @(negedge clk);
            rd_chk(ADDR_CTRL0, {3'h0, en && c[0], 2'h0, en, 1'b0});
            wr_reg(ADDR_CTRL0, {6'h00, en, 1'b0});
            p0 = 1'b0;
            repeat (2) @(negedge clk);
            rd_chk(ADDR_CTRL0, {3'h0, en && c[1], 2'h0, en, 1'b0});
        end
    endtask
    task automatic t_prio();
        logic [7:0] vt [9];
        vt = '{VEC_PIN0, CMP_V, VEC_G0, VEC_G1, VEC_G2, VEC_CONV, VEC_TB0, VEC_TB1, VEC_PIN1};
        wr_reg(ADDR_EDGE_SEL, 8'h09);
        wr_reg(ADDR_CMP_CTRL, 8'h03);
        wr_reg(ADDR_CTRL0, 8'h0E);
        wr_reg(ADDR_CTRL1, 8'h0F);
        wr_reg(ADDR_CTRL2, 8'h03);
        wr_reg(ADDR_GRP0, 8'h03);
        wr_reg(ADDR_TIMER_GROUP, 8'h0F);
        wr_reg(ADDR_MISC_GROUP, 8'h03);
        p0 = 1'b1;
        p1 = 1'b0;
        cmp = 1'b1;
        pulse(11'h749);
        for (int i = 0; i < 9; i++) begin
            gie_on();
            wait_take(vt[i]);
            ret_do();
        end
        rd_chk(ADDR_GRP0, 8'h13);
        rd_chk(ADDR_TIMER_GROUP, 8'h2F);
        rd_chk(ADDR_MISC_GROUP, 8'h13);
        rd_chk(ADDR_CTRL0, 8'h0E);
        rd_chk(ADDR_CTRL1, 8'h0F);
    endtask
    task automatic t_full();
        int l;
        pulse(11'h600);
        gie_on();
        wait_take(VEC_TB0);
        gie_on();
        l = loads;
        repeat (16) @(negedge clk);
        `CHECK(loads, l)
        ret_do();
        wait_take(VEC_TB1);
        ret_do();
    endtask
    initial begin
        {wr, p0, cmp, ret_req, ev, addr, wd} = '0;
        p1 = 1'b1;
        rst_n = 1'b0;
        repeat (9) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_regs();
        t_gate();
        t_edges();
        t_prio();
        t_full();
        report_and_stop();
    end
endmodule

// File: bench/ic_cpu_model.sv
// Core sequencer and call stack facing the interrupt controller
`timescale 1ns/1ns
module ic_cpu_model import ic_pkg::*; #(
    parameter int PC_W = 13,
    parameter int DEPTH = 1
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic ret_req_i,
    input wire logic push_i,
    input wire logic [PC_W-1:0] push_data_i,
    input wire logic pop_i,
    output logic bnd_o,
    output logic [PC_W-1:0] pc_o,
    output logic ret_o,
    output logic [PC_W-1:0] top_o,
    output logic full_o
);
    logic [PC_W-1:0] stk [DEPTH];
    logic [1:0] cnt;
    int sp;
    assign full_o = (sp == DEPTH);
    // Empty stack shows a changing value, never a stale one
    assign top_o = (sp > 0) ? stk[sp-1] : ~pc_o;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sp <= 0;
            cnt <= 2'h0;
            bnd_o <= 1'b0;
            ret_o <= 1'b0;
            pc_o <= '0;
        end else begin
            // Boundary every fourth cycle, so a take is never prompt by luck
            cnt <= cnt + 2'h1;
            bnd_o <= &cnt;
            ret_o <= ret_req_i;
            pc_o <= pc_o + {{(PC_W-1){1'b0}}, bnd_o};
            if (push_i) begin
                stk[sp] <= push_data_i;
                sp <= sp + 1;
            end else if (pop_i) begin
                sp <= sp - 1;
            end
        end
    end
endmodule

// File: hw/ic_core.sv
// Interrupt controller top: flags, enables, arbitration, vectoring and wake-up
`timescale 1ns/1ns
module ic_core import ic_pkg::*; #(
    parameter int PC_W = 13,
    parameter logic [7:0] CMP_VEC = 8'h08
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic pin0_i,
    input wire logic pin1_i,
    input wire logic cmp_out_i,
    input wire logic tmr0_period_evt_i,
    input wire logic tmr0_cmpa_evt_i,
    input wire logic tmr1_period_evt_i,
    input wire logic tmr1_cmpa_evt_i,
    input wire logic tmr2_period_evt_i,
    input wire logic tmr2_cmpa_evt_i,
    input wire logic low_volt_evt_i,
    input wire logic nv_write_done_evt_i,
    input wire logic conv_done_evt_i,
    input wire logic tb0_evt_i,
    input wire logic tb1_evt_i,
    input wire logic instr_boundary_i,
    input wire logic [PC_W-1:0] next_pc_i,
    input wire logic return_from_irq_instr_i,
    input wire logic [PC_W-1:0] stack_top_i,
    input wire logic stack_full_i,
    output logic stack_push_o,
    output logic [PC_W-1:0] stack_push_data_o,
    output logic stack_pop_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_load_addr_o,
    output logic wake_o
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] grp0;
        logic [7:0] timer_group_irq_ctrl;
        logic [7:0] misc_group_irq_ctrl;
        logic [7:0] ext_edge_select_reg;
        logic [7:0] cmp_ctrl_reg;
        logic [7:0] rdata;
        logic push;
        logic [PC_W-1:0] push_data;
        logic pop;
        logic pc_load;
        logic [PC_W-1:0] pc_addr;
        logic wake;
    } ic_state_t;

    ic_state_t s;
    ic_state_t next_s;

    logic [2:0] edge_evt;
    logic [NUM_SRC-1:0] req_flag;
    logic [NUM_SRC-1:0] req_en;
    logic win_valid;
    logic [SRC_W-1:0] win_idx;

    // ****************************************
    // Bit map helpers
    // ****************************************
    // One map serves arbitration and flag update, so the two cannot drift apart
    function automatic logic [NUM_SRC-1:0] gather_flags(input logic [7:0] c0, input logic [7:0] c1,
        input logic [7:0] c2);
        logic [NUM_SRC-1:0] f;
        f = '0;
        f[SRC_PIN0] = c0[B_PIN0_F];
        f[SRC_CMP] = c0[B_CMP_F];
        f[SRC_G0] = c0[B_G0_F];
        f[SRC_G1] = c1[B_G1_F];
        f[SRC_G2] = c1[B_G2_F];
        f[SRC_CONV] = c1[B_CONV_F];
        f[SRC_TB0] = c1[B_TB0_F];
        f[SRC_TB1] = c2[B_TB1_F];
        f[SRC_PIN1] = c2[B_PIN1_F];
        return f;
    endfunction

    function automatic logic [NUM_SRC-1:0] gather_enables(input logic [7:0] c0, input logic [7:0] c1,
        input logic [7:0] c2);
        logic [NUM_SRC-1:0] e;
        e = '0;
        e[SRC_PIN0] = c0[B_PIN0_EN];
        e[SRC_CMP] = c0[B_CMP_EN];
        e[SRC_G0] = c0[B_G0_EN];
        e[SRC_G1] = c1[B_G1_EN];
        e[SRC_G2] = c1[B_G2_EN];
        e[SRC_CONV] = c1[B_CONV_EN];
        e[SRC_TB0] = c1[B_TB0_EN];
        e[SRC_TB1] = c2[B_TB1_EN];
        e[SRC_PIN1] = c2[B_PIN1_EN];
        return e;
    endfunction

    // A contained event raises its group only while its own enable is set
    function automatic logic group_hit(input logic [3:0] evt, input logic [7:0] ctrl);
        return |(evt & ctrl[3:0]);
    endfunction

    // Hardware only ever sets contained flags; clearing them is left to software
    function automatic logic [7:0] merge_sub(input logic [7:0] ctrl, input logic [3:0] evt);
        logic [7:0] r;
        r = ctrl;
        r[SUB_FLAG_LSB +: 4] = ctrl[SUB_FLAG_LSB +: 4] | evt;
        return r;
    endfunction

    // Counts only a contained flag going from clear to set
    function automatic logic sub_new(input logic [3:0] evt, input logic [7:0] ctrl);
        return |(evt & ~ctrl[SUB_FLAG_LSB +: 4]);
    endfunction

    // ****************************************
    // Edge detection and arbitration
    // ****************************************
    ic_edge_det #(.N(3)) u_edge (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .level_i({cmp_out_i, pin1_i, pin0_i}),
        .sel_i({s.cmp_ctrl_reg[B_CMP_SEL +: 2], s.ext_edge_select_reg[B_PIN1_SEL +: 2],
                s.ext_edge_select_reg[B_PIN0_SEL +: 2]}),
        // Comparator flag follows the output regardless of its enable
        .en_i({1'b1, s.ctrl2[B_PIN1_EN], s.ctrl0[B_PIN0_EN]}),
        .evt_o(edge_evt)
    );

    assign req_flag = gather_flags(s.ctrl0, s.ctrl1, s.ctrl2);
    assign req_en = gather_enables(s.ctrl0, s.ctrl1, s.ctrl2);

    ic_prio #(.N(NUM_SRC)) u_prio (
        .req_i(req_flag & req_en),
        .valid_o(win_valid),
        .idx_o(win_idx)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic take;
        logic [NUM_SRC-1:0] clr;
        logic [NUM_SRC-1:0] set;
        logic [NUM_SRC-1:0] flg;
        logic [3:0] g0_set;
        logic [3:0] g1_set;
        logic [3:0] g2_set;
        take = 1'b0;
        clr = '0;
        set = '0;
        flg = '0;
        g0_set = '0;
        g1_set = '0;
        g2_set = '0;
        next_s = s;
        next_s.push = 1'b0;
        next_s.pop = 1'b0;
        next_s.pc_load = 1'b0;
        next_s.wake = 1'b0;

        // Software writes land first so a hardware set in the same cycle wins
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_CTRL0: next_s.ctrl0 = reg_wdata_i & MASK_CTRL0;
                ADDR_CTRL1: next_s.ctrl1 = reg_wdata_i & MASK_CTRL1;
                ADDR_CTRL2: next_s.ctrl2 = reg_wdata_i & MASK_CTRL2;
                ADDR_GRP0: next_s.grp0 = reg_wdata_i & MASK_GRP0;
                ADDR_TIMER_GROUP: next_s.timer_group_irq_ctrl = reg_wdata_i & MASK_TIMER_GROUP;
                ADDR_MISC_GROUP: next_s.misc_group_irq_ctrl = reg_wdata_i & MASK_MISC_GROUP;
                ADDR_EDGE_SEL: next_s.ext_edge_select_reg = reg_wdata_i & MASK_EDGE_SEL;
                ADDR_CMP_CTRL: next_s.cmp_ctrl_reg = reg_wdata_i & MASK_CMP_CTRL;
                default: ;
            endcase
        end

        // ****************************************
        // Contained source flags, set on their own events
        // ****************************************
        g0_set = {2'b00, tmr0_cmpa_evt_i, tmr0_period_evt_i};
        g1_set = {tmr2_cmpa_evt_i, tmr2_period_evt_i, tmr1_cmpa_evt_i, tmr1_period_evt_i};
        g2_set = {2'b00, nv_write_done_evt_i, low_volt_evt_i};
        next_s.grp0 = merge_sub(next_s.grp0, g0_set);
        next_s.timer_group_irq_ctrl = merge_sub(next_s.timer_group_irq_ctrl, g1_set);
        next_s.misc_group_irq_ctrl = merge_sub(next_s.misc_group_irq_ctrl, g2_set);

        // ****************************************
        // Primary source events
        // ****************************************
        set[SRC_PIN0] = edge_evt[0];
        set[SRC_PIN1] = edge_evt[1];
        set[SRC_CMP] = edge_evt[2];
        set[SRC_G0] = group_hit(g0_set, s.grp0);
        set[SRC_G1] = group_hit(g1_set, s.timer_group_irq_ctrl);
        set[SRC_G2] = group_hit(g2_set, s.misc_group_irq_ctrl);
        set[SRC_CONV] = conv_done_evt_i;
        set[SRC_TB0] = tb0_evt_i;
        set[SRC_TB1] = tb1_evt_i;

        // ****************************************
        // Take and return
        // ****************************************
        if (return_from_irq_instr_i) begin
            next_s.pop = 1'b1;
            next_s.pc_load = 1'b1;
            next_s.pc_addr = stack_top_i;
        end else if (instr_boundary_i && s.ctrl0[B_GIE] && !stack_full_i && win_valid) begin
            take = 1'b1;
        end

        if (take) begin
            next_s.push = 1'b1;
            next_s.push_data = next_pc_i;
            next_s.pc_load = 1'b1;
            next_s.pc_addr = {{(PC_W - 8){1'b0}}, ic_vector(win_idx, CMP_VEC)};
            next_s.ctrl0[B_GIE] = 1'b0;
            // Only the winner's own flag; contained sources stay for software
            clr[win_idx] = 1'b1;
        end

        flg = (gather_flags(next_s.ctrl0, next_s.ctrl1, next_s.ctrl2) & ~clr) | set;
        next_s.ctrl0[B_PIN0_F] = flg[SRC_PIN0];
        next_s.ctrl0[B_CMP_F] = flg[SRC_CMP];
        next_s.ctrl0[B_G0_F] = flg[SRC_G0];
        next_s.ctrl1[B_G1_F] = flg[SRC_G1];
        next_s.ctrl1[B_G2_F] = flg[SRC_G2];
        next_s.ctrl1[B_CONV_F] = flg[SRC_CONV];
        next_s.ctrl1[B_TB0_F] = flg[SRC_TB0];
        next_s.ctrl2[B_TB1_F] = flg[SRC_TB1];
        next_s.ctrl2[B_PIN1_F] = flg[SRC_PIN1];

        // A flag preset before sleep yields no new set, hence no wake
        next_s.wake = (|(set & ~req_flag)) || sub_new(g0_set, s.grp0) || sub_new(g1_set, s.timer_group_irq_ctrl)
            || sub_new(g2_set, s.misc_group_irq_ctrl);

        // ****************************************
        // Read back
        // ****************************************
        case (reg_addr_i)
            ADDR_CTRL0: next_s.rdata = s.ctrl0;
            ADDR_CTRL1: next_s.rdata = s.ctrl1;
            ADDR_CTRL2: next_s.rdata = s.ctrl2;
            ADDR_GRP0: next_s.rdata = s.grp0;
            ADDR_TIMER_GROUP: next_s.rdata = s.timer_group_irq_ctrl;
            ADDR_MISC_GROUP: next_s.rdata = s.misc_group_irq_ctrl;
            ADDR_EDGE_SEL: next_s.rdata = s.ext_edge_select_reg;
            ADDR_CMP_CTRL: next_s.rdata = s.cmp_ctrl_reg;
            default: next_s.rdata = RST_REG;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata_o = s.rdata;
    assign stack_push_o = s.push;
    assign stack_push_data_o = s.push_data;
    assign stack_pop_o = s.pop;
    assign pc_load_o = s.pc_load;
    assign pc_load_addr_o = s.pc_addr;
    assign wake_o = s.wake;
endmodule

// File: hw/ic_edge_det.sv
// Edge detectors for the external pins and the comparator output
`timescale 1ns/1ns
module ic_edge_det import ic_pkg::*; #(
    parameter int N = 3
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [N-1:0] level_i,
    input wire logic [2*N-1:0] sel_i,
    input wire logic [N-1:0] en_i,
    output logic [N-1:0] evt_o
);
    typedef struct packed {
        logic [N-1:0] prev;
    } ic_edge_state_t;

    ic_edge_state_t s;
    ic_edge_state_t next_s;

    always_comb begin
        next_s.prev = level_i;
        for (int i = 0; i < N; i++) begin
            // History keeps running while gated so enabling never yields a false edge
            evt_o[i] = en_i[i] && ic_edge_hit(sel_i[2*i +: 2], s.prev[i], level_i[i]);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end
endmodule

// File: hw/ic_pkg.sv
// Package of register map, bit layout, source order and vectors for the interrupt controller
package ic_pkg;

    // ****************************************
    // Register offsets in special data memory
    // ****************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] ADDR_CTRL1 = 4'h1;
    localparam logic [3:0] ADDR_CTRL2 = 4'h2;
    localparam logic [3:0] ADDR_GRP0 = 4'h3;
    localparam logic [3:0] ADDR_TIMER_GROUP = 4'h4;
    localparam logic [3:0] ADDR_MISC_GROUP = 4'h5;
    localparam logic [3:0] ADDR_EDGE_SEL = 4'h6;
    localparam logic [3:0] ADDR_CMP_CTRL = 4'h7;

    // ****************************************
    // Implemented bits and reset values
    // ****************************************
    localparam logic [7:0] MASK_CTRL0 = 8'h7F;
    localparam logic [7:0] MASK_CTRL1 = 8'hFF;
    localparam logic [7:0] MASK_CTRL2 = 8'h33;
    localparam logic [7:0] MASK_GRP0 = 8'h33;
    localparam logic [7:0] MASK_TIMER_GROUP = 8'hFF;
    localparam logic [7:0] MASK_MISC_GROUP = 8'h33;
    localparam logic [7:0] MASK_EDGE_SEL = 8'h0F;
    localparam logic [7:0] MASK_CMP_CTRL = 8'h03;
    localparam logic [7:0] RST_REG = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int B_GIE = 0;
    localparam int B_PIN0_EN = 1;
    localparam int B_CMP_EN = 2;
    localparam int B_G0_EN = 3;
    localparam int B_PIN0_F = 4;
    localparam int B_CMP_F = 5;
    localparam int B_G0_F = 6;
    localparam int B_G1_EN = 0;
    localparam int B_G2_EN = 1;
    localparam int B_CONV_EN = 2;
    localparam int B_TB0_EN = 3;
    localparam int B_G1_F = 4;
    localparam int B_G2_F = 5;
    localparam int B_CONV_F = 6;
    localparam int B_TB0_F = 7;
    localparam int B_TB1_EN = 0;
    localparam int B_PIN1_EN = 1;
    localparam int B_TB1_F = 4;
    localparam int B_PIN1_F = 5;
    // Sub-source flags sit in the upper nibble, enables in the lower one
    localparam int SUB_FLAG_LSB = 4;
    localparam int B_PIN0_SEL = 0;
    localparam int B_PIN1_SEL = 2;
    localparam int B_CMP_SEL = 0;

    // ****************************************
    // Sources, lowest index is highest priority
    // ****************************************
    localparam int NUM_SRC = 9;
    localparam int SRC_W = 4;
    localparam int SRC_PIN0 = 0;
    localparam int SRC_CMP = 1;
    localparam int SRC_G0 = 2;
    localparam int SRC_G1 = 3;
    localparam int SRC_G2 = 4;
    localparam int SRC_CONV = 5;
    localparam int SRC_TB0 = 6;
    localparam int SRC_TB1 = 7;
    localparam int SRC_PIN1 = 8;

    localparam logic [7:0] VEC_PIN0 = 8'h04;
    localparam logic [7:0] VEC_G0 = 8'h0C;
    localparam logic [7:0] VEC_G1 = 8'h10;
    localparam logic [7:0] VEC_G2 = 8'h14;
    localparam logic [7:0] VEC_CONV = 8'h18;
    localparam logic [7:0] VEC_TB0 = 8'h1C;
    localparam logic [7:0] VEC_TB1 = 8'h20;
    localparam logic [7:0] VEC_PIN1 = 8'h24;

    // ****************************************
    // Edge select codes
    // ****************************************
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    function automatic logic ic_edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        case (sel)
            EDGE_RISE: ic_edge_hit = !prev && cur;
            EDGE_FALL: ic_edge_hit = prev && !cur;
            EDGE_BOTH: ic_edge_hit = prev != cur;
            default: ic_edge_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] ic_vector(input logic [3:0] src, input logic [7:0] cmp_vec);
        case (src)
            4'h0: ic_vector = VEC_PIN0;
            4'h1: ic_vector = cmp_vec;
            4'h2: ic_vector = VEC_G0;
            4'h3: ic_vector = VEC_G1;
            4'h4: ic_vector = VEC_G2;
            4'h5: ic_vector = VEC_CONV;
            4'h6: ic_vector = VEC_TB0;
            4'h7: ic_vector = VEC_TB1;
            default: ic_vector = VEC_PIN1;
        endcase
    endfunction

endpackage

// File: hw/ic_prio.sv
// Fixed priority picker, lowest index wins
`timescale 1ns/1ns
module ic_prio import ic_pkg::*; #(
    parameter int N = 9
) (
    input wire logic [N-1:0] req_i,
    output logic valid_o,
    output logic [SRC_W-1:0] idx_o
);
    always_comb begin
        valid_o = |req_i;
        idx_o = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                idx_o = SRC_W'(i);
            end
        end
    end
endmodule
